/* File: dv/rel_top_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module rel_top_test
	import rel_pkg::*;
;
	logic            clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic [7:0]      wb_adr_i;
	logic [3:0]      wb_sel_i, err_chan_i;
	logic [31:0]     wb_dat_i, wb_dat_o, rd;
	logic            err_valid_i, err_chan_known_i, err_contin_i;
	rel_kind_t       err_kind_i;
	logic [1:0]      err_lp_i;
	logic [AW-1:0]   err_addr_i;
	logic [5:0]      err_lsb_i;
	logic [NLP-1:0]  check_exc_o;
	int              fail_count, comparisons;

	rel_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .err_valid_i, .err_kind_i, .err_lp_i, .err_chan_i,
		.err_chan_known_i, .err_addr_i, .err_lsb_i, .err_contin_i, .check_exc_o, .irq_o);

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task test_done;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	// Whole run is well under two thousand cycles.
	initial begin
		#20000;
		fail_count++;
		test_done();
	end

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task go(input rel_kind_t k, input logic [1:0] p, input logic [3:0] c,
		input logic kn, input logic ct, input logic lcl);
		logic [15:0] code;
		logic [31:0] a;
		logic [5:0]  lsb;
		logic [7:0]  base, other;
		logic [3:0]  g;
		logic        ra;
		ra = (k == REL_DATA_LOAD) || (k == REL_FETCH);
		code = (k == REL_SCRUB) ? {12'h00c, kn ? c : 4'hf} : (k == REL_LLC_WB) ? 16'h017a :
			(k == REL_DATA_LOAD) ? 16'h0134 : 16'h0150;
		a = {8'hc3, 6'h00, p, c, 12'h9a5};
		lsb = {p, c};
		base = p[1] ? OFS_BANK + BANK_STRIDE : OFS_BANK;
		other = p[1] ? OFS_BANK : OFS_BANK + BANK_STRIDE;
		wb(1'b1, OFS_CTRL, {31'h0, lcl}, 4'h1);
		for (int i = 0; i < NLP; i++) wb(1'b1, OFS_GSTAT + 8'(4 * i), 32'h0, 4'h1);
		wb(1'b1, base + OFS_B_STAT, 32'h0, 4'h8);
		wb(1'b1, other + OFS_B_STAT, 32'h0, 4'h8);
		@(posedge clk_i);
		err_valid_i      <= 1'b1;
		err_kind_i       <= k;
		err_lp_i         <= p;
		err_chan_i       <= c;
		err_chan_known_i <= kn;
		err_contin_i     <= ct;
		err_addr_i       <= a;
		err_lsb_i        <= lsb;
		@(posedge clk_i);
		err_valid_i <= 1'b0;
		wb(1'b0, base + OFS_B_STAT, 32'h0, 4'hf);
		`CHK(rd, {8'hbd, ra, 7'h00, code})
		`CHK(rd[FILTER_BIT], 1'b0)
		wb(1'b0, base + OFS_B_LOC, 32'h0, 4'hf);
		`CHK(rd, a)
		wb(1'b0, base + OFS_B_XINFO, 32'h0, 4'hf);
		`CHK(rd, {23'h0, ADDR_MODE_PHYS, lsb})
		wb(1'b0, other + OFS_B_STAT, 32'h0, 4'hf);
		`CHK(rd, 32'h0)
		for (int i = 0; i < NLP; i++) begin
			if (ra && i == int'(p)) g = {lcl, 1'b1, 1'b1, ct};
			else if (ra && lcl) g = 4'h0;
			else g = 4'b0101;
			wb(1'b0, OFS_GSTAT + 8'(4 * i), 32'h0, 4'hf);
			`CHK(rd, {28'h0, g})
			`CHK(check_exc_o[i], g[2])
		end
	endtask : go

	initial begin
		fail_count = 0;
		comparisons = 0;
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, err_valid_i, err_chan_known_i, err_contin_i} = '0;
		wb_adr_i = '0;
		wb_sel_i = '0;
		wb_dat_i = '0;
		err_kind_i = REL_SCRUB;
		err_lp_i = '0;
		err_chan_i = '0;
		err_addr_i = '0;
		err_lsb_i = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK(check_exc_o, 4'h0)
		`CHK(irq_o, 1'b0)
		wb(1'b0, OFS_IRQ_MASK, 32'h0, 4'hf);
		`CHK(rd, RST_WORD)
		wb(1'b1, 8'h80, 32'hffff_ffff, 4'hf);
		wb(1'b0, 8'h80, 32'h0, 4'hf);
		`CHK(rd, 32'h0)
		go(REL_SCRUB, 2'd0, 4'h5, 1'b1, 1'b0, 1'b0);
		go(REL_SCRUB, 2'd3, 4'h5, 1'b0, 1'b1, 1'b1);
		go(REL_SCRUB, 2'd1, 4'he, 1'b1, 1'b0, 1'b0);
		go(REL_LLC_WB, 2'd1, 4'h3, 1'b1, 1'b0, 1'b1);
		go(REL_DATA_LOAD, 2'd2, 4'h1, 1'b1, 1'b1, 1'b0);
		go(REL_FETCH, 2'd1, 4'h2, 1'b1, 1'b0, 1'b0);
		go(REL_DATA_LOAD, 2'd0, 4'h7, 1'b1, 1'b0, 1'b1);
		go(REL_FETCH, 2'd3, 4'h9, 1'b1, 1'b1, 1'b1);
		`CHK(irq_o, 1'b0)
		wb(1'b1, OFS_IRQ_MASK, 32'h4, 4'h1);
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b1)
		wb(1'b0, OFS_IRQ_STAT, 32'h0, 4'hf);
		`CHK(rd, 32'hf)
		wb(1'b0, OFS_IRQ_STAT, 32'h0, 4'hf);
		`CHK(rd, 32'h0)
		repeat (2) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		test_done();
	end
endmodule : rel_top_test

/* File: hw/rel_top.sv */
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rel_top
	import rel_pkg::*;
(
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	input  wire logic            err_valid_i,
	input  wire rel_kind_t       err_kind_i,
	input  wire logic [1:0]      err_lp_i,
	input  wire logic [3:0]      err_chan_i,
	input  wire logic            err_chan_known_i,
	input  wire logic [AW-1:0]   err_addr_i,
	input  wire logic [5:0]      err_lsb_i,
	input  wire logic            err_contin_i,
	output logic      [NLP-1:0]  check_exc_o,
	output logic                 irq_o
);
	logic [31:0]    bank_stat_ff [NBANK];
	logic [AW-1:0]  bank_loc_ff  [NBANK];
	logic [31:0]    bank_xinfo_ff[NBANK];
	logic [3:0]     gstat_ff     [NLP];
	logic           local_en_ff;
	logic [3:0]     irq_stat_ff;
	logic [3:0]     irq_mask_ff;
	logic           ack_ff;
	logic [31:0]    dat_ff;
	logic           irq_ff;
	logic           wb_req;
	logic           wb_wr;
	logic           wb_rd;
	logic           optional_cls;
	logic           local_dlv;
	logic [15:0]    nxt_code;
	logic [31:0]    nxt_stat;
	logic [31:0]    nxt_xinfo;
	logic [3:0]     chan;
	logic [0:0]     tgt_bank;
	logic [31:0]    nxt_dat;

	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wb_wr  = wb_req & wb_we_i;
	assign wb_rd  = wb_req & ~wb_we_i;

	// Error record composition.
	always_comb begin
		optional_cls = (err_kind_i == REL_SCRUB) || (err_kind_i == REL_LLC_WB);
		local_dlv    = LOCAL_SUPP & local_en_ff & ~optional_cls;
		tgt_bank     = 1'(err_lp_i / 2'(LP_PER_BANK));
		chan         = err_chan_known_i ? err_chan_i : CHAN_UNKNOWN;
		case (err_kind_i)
			REL_SCRUB: begin
				nxt_code = {3'h0, FILTER_NORMAL, 4'h0, 1'b1, MEM_TXN_SCRUB, chan};
			end
			REL_LLC_WB: begin
				nxt_code = {3'h0, FILTER_NORMAL, CACHE_CLASS, REQ_EVICT, TT_GENERIC, LVL_2};
			end
			REL_DATA_LOAD: begin
				nxt_code = {3'h0, FILTER_NORMAL, CACHE_CLASS, REQ_DATA_RD, TT_DATA, LVL_0};
			end
			default: begin
				nxt_code = {3'h0, FILTER_NORMAL, CACHE_CLASS, REQ_FETCH, TT_INSTR, LVL_0};
			end
		endcase
		nxt_stat = {16'h0, nxt_code};
		nxt_stat[ST_VALID] = 1'b1;
		nxt_stat[ST_UNCOR] = 1'b1;
		nxt_stat[ST_EN]    = 1'b1;
		nxt_stat[ST_XINFO] = 1'b1;
		nxt_stat[ST_LOC]   = 1'b1;
		nxt_stat[ST_SIG]   = 1'b1;
		nxt_stat[ST_LOST]  = 1'b0;
		nxt_stat[ST_PCC]   = 1'b0;
		nxt_stat[ST_AR]    = ~optional_cls;
		nxt_xinfo = {23'h0, ADDR_MODE_PHYS, err_lsb_i};
	end

	// One bank per pair of processors; a write to a bank's status word clears that status word only.
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic sel_b;
		assign sel_b = err_valid_i && (tgt_bank == 1'(b));
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				bank_stat_ff[b]  <= RST_WORD;
				bank_loc_ff[b]   <= RST_WORD;
				bank_xinfo_ff[b] <= RST_WORD;
			end else if (sel_b) begin
				bank_stat_ff[b]  <= nxt_stat;
				bank_loc_ff[b]   <= err_addr_i;
				bank_xinfo_ff[b] <= nxt_xinfo;
			end else if (wb_wr && wb_sel_i[3] &&
			             wb_adr_i == OFS_BANK + 8'(b) * BANK_STRIDE + OFS_B_STAT) begin
				bank_stat_ff[b] <= RST_WORD;
			end
		end
	end

	// Per-processor global status; the in-progress bit drives the exception.
	for (genvar p = 0; p < NLP; p++) begin : g_lp
		logic hit_p;
		logic aff_p;
		assign aff_p = (err_lp_i == 2'(p));
		assign hit_p = err_valid_i && (!local_dlv || aff_p);
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				gstat_ff[p] <= 4'h0;
			end else if (hit_p) begin
				gstat_ff[p][GS_INPRG] <= 1'b1;
				gstat_ff[p][GS_LOCAL] <= local_dlv;
				if (optional_cls) begin
					gstat_ff[p][GS_RPOK] <= 1'b1;
					gstat_ff[p][GS_EPR]  <= 1'b0;
				end else if (aff_p) begin
					gstat_ff[p][GS_RPOK] <= err_contin_i;
					gstat_ff[p][GS_EPR]  <= 1'b1;
				end else begin
					gstat_ff[p][GS_RPOK] <= 1'b1;
					gstat_ff[p][GS_EPR]  <= 1'b0;
				end
			end else if (wb_wr && wb_sel_i[0] && wb_adr_i == OFS_GSTAT + 8'(p * 4)) begin
				gstat_ff[p] <= wb_dat_i[3:0];
			end
		end
		assign check_exc_o[p] = gstat_ff[p][GS_INPRG];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			local_en_ff <= 1'b0;
			irq_mask_ff <= 4'h0;
		end else if (wb_wr && wb_sel_i[0]) begin
			if (wb_adr_i == OFS_CTRL) begin
				local_en_ff <= wb_dat_i[0];
			end else if (wb_adr_i == OFS_IRQ_MASK) begin
				irq_mask_ff <= wb_dat_i[3:0];
			end
		end
	end

	// Sticky event bits per error kind; a read clears them, a new event wins.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_ff <= 4'h0;
		end else begin
			irq_stat_ff <= ((wb_rd && wb_adr_i == OFS_IRQ_STAT) ? 4'h0 : irq_stat_ff) |
			               ({3'h0, err_valid_i} << err_kind_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
		end
	end
	assign irq_o = irq_ff;

	always_comb begin
		nxt_dat = RST_WORD;
		if (wb_adr_i == OFS_CTRL) begin
			nxt_dat = {31'h0, local_en_ff};
		end else if (wb_adr_i == OFS_IRQ_STAT) begin
			nxt_dat = {28'h0, irq_stat_ff};
		end else if (wb_adr_i == OFS_IRQ_MASK) begin
			nxt_dat = {28'h0, irq_mask_ff};
		end else begin
			for (int b = 0; b < NBANK; b++) begin
				if (wb_adr_i == OFS_BANK + 8'(b) * BANK_STRIDE + OFS_B_STAT) begin
					nxt_dat = bank_stat_ff[b];
				end else if (wb_adr_i == OFS_BANK + 8'(b) * BANK_STRIDE + OFS_B_LOC) begin
					nxt_dat = bank_loc_ff[b];
				end else if (wb_adr_i == OFS_BANK + 8'(b) * BANK_STRIDE + OFS_B_XINFO) begin
					nxt_dat = bank_xinfo_ff[b];
				end
			end
			for (int p = 0; p < NLP; p++) begin
				if (wb_adr_i == OFS_GSTAT + 8'(p * 4)) begin
					nxt_dat = {28'h0, gstat_ff[p]};
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= RST_WORD;
		end else begin
			ack_ff <= wb_req;
			dat_ff <= wb_rd ? nxt_dat : dat_ff;
		end
	end
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_scrub_code;
		err_valid_i && err_kind_i == REL_SCRUB && tgt_bank == 1'b0 |=>
			bank_stat_ff[0][15:4] == 12'h00c;
	endproperty
	a_scrub_code: assert property (p_scrub_code) else $error("scrub code wrong");

	property p_chan_unknown;
		err_valid_i && err_kind_i == REL_SCRUB && !err_chan_known_i && tgt_bank == 1'b1 |=>
			bank_stat_ff[1][3:0] == 4'hf;
	endproperty
	a_chan_unknown: assert property (p_chan_unknown) else $error("channel not 1111");

	property p_wb_code;
		err_valid_i && err_kind_i == REL_LLC_WB && tgt_bank == 1'b0 |=>
			bank_stat_ff[0][15:0] == 16'h017a && !bank_stat_ff[0][ST_AR];
	endproperty
	a_wb_code: assert property (p_wb_code) else $error("writeback record wrong");

	property p_load_code;
		err_valid_i && err_kind_i == REL_DATA_LOAD && tgt_bank == 1'b0 |=>
			bank_stat_ff[0][15:0] == 16'h0134 && bank_stat_ff[0][ST_AR];
	endproperty
	a_load_code: assert property (p_load_code) else $error("load record wrong");

	property p_fetch_code;
		err_valid_i && err_kind_i == REL_FETCH && tgt_bank == 1'b1 |=>
			bank_stat_ff[1][15:0] == 16'h0150;
	endproperty
	a_fetch_code: assert property (p_fetch_code) else $error("fetch code wrong");

	property p_filter;
		bank_stat_ff[0][ST_VALID] |-> !bank_stat_ff[0][FILTER_BIT];
	endproperty
	a_filter: assert property (p_filter) else $error("filter bit set");

	property p_flags;
		err_valid_i && tgt_bank == 1'b0 |=> bank_stat_ff[0][31:24] == 8'hbd;
	endproperty
	a_flags: assert property (p_flags) else $error("status flags wrong");

	property p_xinfo;
		err_valid_i && tgt_bank == 1'b1 ##1 1'b1 |->
			bank_xinfo_ff[1][8:6] == 3'h2 && bank_xinfo_ff[1][5:0] == $past(err_lsb_i);
	endproperty
	a_xinfo: assert property (p_xinfo) else $error("extra info wrong");

	property p_bcast;
		err_valid_i && !local_en_ff |=> &check_exc_o ##1 $stable(local_en_ff);
	endproperty
	a_bcast: assert property (p_bcast) else $error("exception not broadcast");

	property p_opt_ptrs;
		err_valid_i && optional_cls |=> gstat_ff[3][1:0] == 2'h1 && gstat_ff[0][1:0] == 2'h1;
	endproperty
	a_opt_ptrs: assert property (p_opt_ptrs) else $error("optional pointers wrong");

	property p_contin;
		err_valid_i && !optional_cls && err_contin_i && err_lp_i == 2'h2 |=>
			gstat_ff[2][1:0] == 2'h3;
	endproperty
	a_contin: assert property (p_contin) else $error("continuable pointers wrong");

	property p_nocontin;
		err_valid_i && !optional_cls && !err_contin_i && err_lp_i == 2'h1 |=>
			!gstat_ff[1][GS_RPOK];
	endproperty
	a_nocontin: assert property (p_nocontin) else $error("restart ok not cleared");

	property p_observer;
		err_valid_i && !optional_cls && !local_dlv && err_lp_i != 2'h0 |=>
			gstat_ff[0][1:0] == 2'h1;
	endproperty
	a_observer: assert property (p_observer) else $error("observer pointers wrong");

	property p_loc;
		err_valid_i && tgt_bank == 1'b0 |=> bank_loc_ff[0] == $past(err_addr_i);
	endproperty
	a_loc: assert property (p_loc) else $error("location not logged");

	property p_loc_hi;
		err_valid_i && tgt_bank == 1'b1 |=> bank_loc_ff[1] == $past(err_addr_i);
	endproperty
	a_loc_hi: assert property (p_loc_hi) else $error("location not logged");

	property p_ar_flag;
		err_valid_i && !optional_cls && tgt_bank == 1'b1 |=>
			bank_stat_ff[1][ST_AR] && bank_stat_ff[1][31:24] == 8'hbd;
	endproperty
	a_ar_flag: assert property (p_ar_flag) else $error("required flags wrong");

	property p_local;
		err_valid_i && local_dlv && err_lp_i == 2'h3 && !wb_wr |=>
			gstat_ff[3][GS_LOCAL] && check_exc_o[3] && gstat_ff[0] == $past(gstat_ff[0]);
	endproperty
	a_local: assert property (p_local) else $error("local delivery wrong");

	property p_cons_bank;
		err_valid_i && !optional_cls && err_lp_i == 2'h3 |=>
			bank_stat_ff[1][ST_VALID] && bank_stat_ff[1][ST_AR];
	endproperty
	a_cons_bank: assert property (p_cons_bank) else $error("wrong bank");

	property p_share;
		err_valid_i && tgt_bank == 1'b0 && !wb_wr |=>
			bank_stat_ff[1] == $past(bank_stat_ff[1]);
	endproperty
	a_share: assert property (p_share) else $error("shared bank leaked");

	property p_apart;
		err_valid_i && !optional_cls && !local_dlv && err_lp_i == 2'h1 |=>
			gstat_ff[1][GS_EPR] && !gstat_ff[0][GS_EPR] && !gstat_ff[3][GS_EPR];
	endproperty
	a_apart: assert property (p_apart) else $error("affected not told apart");

	property p_ack_answer;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not answered");

	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	property p_irq_level;
		(|(irq_stat_ff & irq_mask_ff)) |=> irq_o;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	property p_irq_quiet;
		!(|(irq_stat_ff & irq_mask_ff)) |=> !irq_o;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without cause");

	property p_irq_sticky;
		irq_stat_ff[2] && !(wb_rd && wb_adr_i == OFS_IRQ_STAT) |=> irq_stat_ff[2];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("event bit lost");

	property p_irq_set;
		err_valid_i && err_kind_i == REL_FETCH |=> irq_stat_ff[3];
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("event bit not set");

	c_scrub: cover property (err_valid_i && err_kind_i == REL_SCRUB);
	c_local: cover property (err_valid_i && local_dlv ##1 check_exc_o == 4'h1 << 0);
	c_irq:   cover property (err_valid_i ##[1:4] irq_o);
	c_nocontin: cover property (err_valid_i && !optional_cls && !err_contin_i);
	c_irq_clr: cover property (wb_rd && wb_adr_i == OFS_IRQ_STAT ##1 irq_stat_ff == 4'h0);
endmodule : rel_top

/* File: include/rel_pkg.sv */
package rel_pkg;
	localparam int NLP          = 4;
	localparam int NBANK        = 2;
	localparam int LP_PER_BANK  = NLP / NBANK;
	localparam int AW           = 32;
	localparam bit LOCAL_SUPP   = 1'b1;
	// Compound code pieces.
	localparam logic [2:0] MEM_TXN_SCRUB = 3'h4;
	localparam logic [3:0] CHAN_UNKNOWN  = 4'hf;
	localparam logic [3:0] REQ_EVICT     = 4'h7;
	localparam logic [3:0] REQ_DATA_RD   = 4'h3;
	localparam logic [3:0] REQ_FETCH     = 4'h5;
	localparam logic [1:0] TT_INSTR      = 2'h0;
	localparam logic [1:0] TT_DATA       = 2'h1;
	localparam logic [1:0] TT_GENERIC    = 2'h2;
	localparam logic [1:0] LVL_0         = 2'h0;
	localparam logic [1:0] LVL_2         = 2'h2;
	localparam logic       FILTER_NORMAL = 1'b0;
	localparam logic [3:0] CACHE_CLASS   = 4'h1;
	localparam int         FILTER_BIT    = 12;
	// Bank status field positions.
	localparam int ST_VALID = 31;
	localparam int ST_LOST  = 30;
	localparam int ST_UNCOR = 29;
	localparam int ST_EN    = 28;
	localparam int ST_XINFO = 27;
	localparam int ST_LOC   = 26;
	localparam int ST_PCC   = 25;
	localparam int ST_SIG   = 24;
	localparam int ST_AR    = 23;
	// Extra-information fields.
	localparam logic [2:0] ADDR_MODE_PHYS = 3'h2;
	localparam int         XI_MODE_LSB    = 6;
	// Global status bits.
	localparam int GS_RPOK  = 0;
	localparam int GS_EPR   = 1;
	localparam int GS_INPRG = 2;
	localparam int GS_LOCAL = 3;
	// Register byte offsets and the reset word.
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_BANK     = 8'h10;
	localparam logic [7:0] BANK_STRIDE  = 8'h10;
	localparam logic [7:0] OFS_B_STAT   = 8'h00;
	localparam logic [7:0] OFS_B_LOC    = 8'h04;
	localparam logic [7:0] OFS_B_XINFO  = 8'h08;
	localparam logic [7:0] OFS_GSTAT    = 8'h40;
	localparam logic [31:0] RST_WORD    = 32'h0000_0000;
	typedef enum logic [1:0] {
		REL_SCRUB,
		REL_LLC_WB,
		REL_DATA_LOAD,
		REL_FETCH
	} rel_kind_t;
endpackage : rel_pkg
